/* src/prog_pin_pulse_and_trigger_out.sv */
/*
  Two programmable rear-panel pins (constant high, constant low or pulse
  train) and one trigger-out pin, set over an Avalon-MM slave.
  Assumes a one-cycle millisecond tick, synchronous status inputs from the
  output stage and sequencer, and a master that honours waitrequest.
*/
// Overview of operation
// - Finite pulse count 1..9999, exactly that emitted
// - Count minus one pulses endlessly
// - Duty ratio zero to one per pin
// - Period 1..3600 ms, pulses repeat
// - Pin states high, low or pulse train
// - Pulse settings act only in pulse mode
// - Second pin independent, identical behaviour
// - Trigger mode off never pulses trigger
// - Idle, state change mode: trigger on/off
// - Idle, every program mode: trigger on programming
// - Running, state change: sequence enable gates triggers
// - Running, every program: trigger per completed step
`include "pin_pulse_params.svh"

module prog_pin_pulse_and_trigger_out (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_ms_tick,
  input wire logic i_output_on,
  input wire logic i_param_programmed,
  input wire logic i_seq_running,
  input wire logic i_seq_state_change_mode_enable,
  input wire logic i_step_done,
  output logic o_prog_pin_one,
  output logic o_prog_pin_two,
  output logic o_trigger_out
);

  // ************************************************************
  // State
  // ************************************************************
  pin_pulse_pkg::state_t s_q; // Registered block state
  pin_pulse_pkg::state_t s_d; // Next block state

  // Trigger pulse length, sized to its counter
  localparam logic [`W_STATE_CHANGE_MODE-1:0] STATE_CHANGE_MODE_LEN = `W_STATE_CHANGE_MODE'(`STATE_CHANGE_MODE_CYCLES);

  // ************************************************************
  // Helpers
  // ************************************************************

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Pin level for a phase: high while phase/period < duty
  function automatic logic high_at(input pin_pulse_pkg::pin_t p);
    logic [`W_PROD-1:0] lhs;
    logic [`W_PROD-1:0] rhs;
    lhs = `W_PROD'(p.ms_cnt) * `W_PROD'(`DUTY_FULL);
    rhs = `W_PROD'(p.duty) * `W_PROD'(p.period);
    // Duty 0 gives rhs 0, never high; full duty is high all period
    return (lhs < rhs);
  endfunction

  // Readback of one pin register field
  function automatic logic [31:0] pin_read(input pin_pulse_pkg::pin_t p,
                                           input logic [1:0] sel);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (sel)
      2'h0: r = {30'h0000_0000, p.mode};
      2'h1: r = {16'h0000, p.count};
      2'h2: r = {22'h00_0000, p.duty};
      2'h3: r = {20'h0_0000, p.period};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    logic [31:0] wv;     // Merged write value
    logic [1:0] fsel;    // Pin field select
    logic psel;          // Pin select
    logic pin_hit;       // Address is a pin register
    logic wr_now;        // Write takes effect this edge
    logic [31:0] rv;     // Read mux result
    logic restart;       // Pin settings rewritten
    logic fire;          // Trigger event this cycle
    logic edge_on;       // Output on/off change
    wv = 32'h0000_0000;
    fsel = i_address[3:2];
    psel = i_address[4];
    pin_hit = (i_address[7:5] == 3'h0);
    wr_now = i_write & ~s_q.waitreq;
    rv = 32'h0000_0000;
    restart = 1'b0;
    fire = 1'b0;
    edge_on = i_output_on ^ s_q.prev_on;
    s_d = s_q;

    // Bus handshake: one wait cycle, then answer for one cycle
    if (s_q.waitreq) begin
      if (i_read | i_write) begin
        s_d.waitreq = 1'b0;
      end
    end else begin
      s_d.waitreq = 1'b1;
    end

    // Read mux, captured as the answer is raised
    if (pin_hit) begin
      rv = pin_read(s_q.pin[psel], fsel);
    end else if (i_address == `OFS_STATE_CHANGE_MODE_MODE) begin
      rv = {30'h0000_0000, s_q.state_change_mode_mode};
    end else if (i_address == `OFS_STATUS) begin
      rv = {26'h000_0000, i_seq_running, s_q.state_change_mode_level,
            s_q.pin[1].done, s_q.pin[0].done,
            s_q.pin[1].level, s_q.pin[0].level};
    end else begin
      // Unmapped address reads zero
      rv = 32'h0000_0000;
    end
    if (s_q.waitreq & i_read) begin
      s_d.rdata = rv;
    end

    // Pulse engines, one per pin
    for (int i = 0; i < 2; i++) begin
      restart = 1'b0;
      // Register writes; out-of-range values are ignored
      if (wr_now && pin_hit && (psel == i[0])) begin
        wv = merge(pin_read(s_q.pin[i], fsel), i_writedata, i_byteenable);
        case (fsel)
          2'h0: begin
            if (wv[`W_MODE-1:0] <= `PIN_PWM) begin
              s_d.pin[i].mode = wv[`W_MODE-1:0];
              restart = 1'b1;
            end
          end
          2'h1: begin
            // Count accepts -1 or 1..9999
            if ((wv[`W_COUNT-1:0] == `COUNT_ENDLESS) ||
                ((wv[`W_COUNT-1:0] >= `COUNT_MIN) &&
                 (wv[`W_COUNT-1:0] <= `COUNT_MAX))) begin
              s_d.pin[i].count = wv[`W_COUNT-1:0];
              restart = 1'b1;
            end
          end
          2'h2: begin
            if (wv[`W_DUTY-1:0] <= `DUTY_FULL) begin
              s_d.pin[i].duty = wv[`W_DUTY-1:0];
              restart = 1'b1;
            end
          end
          2'h3: begin
            if ((wv[`W_PERIOD-1:0] >= `PERIOD_MIN) &&
                (wv[`W_PERIOD-1:0] <= `PERIOD_MAX)) begin
              s_d.pin[i].period = wv[`W_PERIOD-1:0];
              restart = 1'b1;
            end
          end
          default: begin
            restart = 1'b0;
          end
        endcase
      end

      if (restart) begin
        // Any rewrite starts a fresh train from the first pulse
        s_d.pin[i].ms_cnt = `W_PERIOD'(0);
        s_d.pin[i].left = s_d.pin[i].count;
        s_d.pin[i].done = 1'b0;
      end else if ((s_q.pin[i].mode == `PIN_PWM) && !s_q.pin[i].done &&
                   i_ms_tick) begin
        // Advance phase by one millisecond
        if (s_q.pin[i].ms_cnt >= s_q.pin[i].period - `W_PERIOD'(1)) begin
          s_d.pin[i].ms_cnt = `W_PERIOD'(0);
          if (s_q.pin[i].count != `COUNT_ENDLESS) begin
            // Finite train: count completed periods
            if (s_q.pin[i].left <= `COUNT_MIN) begin
              s_d.pin[i].done = 1'b1;
            end else begin
              s_d.pin[i].left = s_q.pin[i].left - `W_COUNT'(1);
            end
          end
          // Endless train never counts down
        end else begin
          s_d.pin[i].ms_cnt = s_q.pin[i].ms_cnt + `W_PERIOD'(1);
        end
      end

      // Pin level from the next state, so the pin flop leads nothing
      case (s_d.pin[i].mode)
        `PIN_HIGH: s_d.pin[i].level = 1'b1;
        `PIN_LOW: s_d.pin[i].level = 1'b0;
        `PIN_PWM: begin
          // Finished train rests low
          s_d.pin[i].level = !s_d.pin[i].done &&
                             high_at(s_d.pin[i]);
        end
        default: s_d.pin[i].level = 1'b0;
      endcase
    end

    // Trigger mode register
    if (wr_now && (i_address == `OFS_STATE_CHANGE_MODE_MODE)) begin
      wv = merge({30'h0000_0000, s_q.state_change_mode_mode}, i_writedata, i_byteenable);
      if (wv[`W_MODE-1:0] <= `STATE_CHANGE_MODE_EVERY_PROGRAM) begin
        s_d.state_change_mode_mode = wv[`W_MODE-1:0];
      end
    end

    // Trigger event selection by mode and sequencer state
    s_d.prev_on = i_output_on;
    case (s_q.state_change_mode_mode)
      `STATE_CHANGE_MODE_OFF: fire = 1'b0;
      `STATE_CHANGE_MODE_STATE_CHANGE: begin
        if (i_seq_running) begin
          fire = edge_on & i_seq_state_change_mode_enable;
        end else begin
          fire = edge_on;
        end
      end
      `STATE_CHANGE_MODE_EVERY_PROGRAM: begin
        if (i_seq_running) begin
          fire = i_step_done;
        end else begin
          fire = i_param_programmed;
        end
      end
      default: fire = 1'b0;
    endcase

    // Fixed-width trigger pulse; a new event restarts it
    if (fire) begin
      s_d.state_change_mode_cnt = STATE_CHANGE_MODE_LEN;
      s_d.state_change_mode_level = 1'b1;
    end else if (s_q.state_change_mode_cnt > `W_STATE_CHANGE_MODE'(1)) begin
      s_d.state_change_mode_cnt = s_q.state_change_mode_cnt - `W_STATE_CHANGE_MODE'(1);
      s_d.state_change_mode_level = 1'b1;
    end else begin
      s_d.state_change_mode_cnt = `W_STATE_CHANGE_MODE'(0);
      s_d.state_change_mode_level = 1'b0;
    end
    // Mode off also cuts a pulse already running
    if (s_q.state_change_mode_mode == `STATE_CHANGE_MODE_OFF) begin
      s_d.state_change_mode_cnt = `W_STATE_CHANGE_MODE'(0);
      s_d.state_change_mode_level = 1'b0;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      // Both pins low, trigger off, bus stalled until a request
      for (int i = 0; i < 2; i++) begin
        s_q.pin[i].mode <= `RST_MODE;
        s_q.pin[i].count <= `RST_COUNT;
        s_q.pin[i].duty <= `RST_DUTY;
        s_q.pin[i].period <= `RST_PERIOD;
        s_q.pin[i].ms_cnt <= `W_PERIOD'(0);
        s_q.pin[i].left <= `RST_COUNT;
        s_q.pin[i].done <= 1'b0;
        s_q.pin[i].level <= 1'b0;
      end
      s_q.state_change_mode_mode <= `STATE_CHANGE_MODE_OFF;
      s_q.state_change_mode_cnt <= `W_STATE_CHANGE_MODE'(0);
      s_q.state_change_mode_level <= 1'b0;
      // Reset value only; first cycle after release may see a false edge
      s_q.prev_on <= 1'b0;
      s_q.waitreq <= 1'b1;
      s_q.rdata <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs, straight from flops
  // ************************************************************
  assign o_prog_pin_one = s_q.pin[0].level;
  assign o_prog_pin_two = s_q.pin[1].level;
  assign o_trigger_out = s_q.state_change_mode_level;
  assign o_readdata = s_q.rdata;
  assign o_waitrequest = s_q.waitreq;

endmodule

/* src/pin_pulse_params.svh */
/*
  Named constants for the programmable pin pulse and trigger-out block:
  register offsets, field widths, encodings, reset values and timing.
  Assumes it is included by bare name from the package and the design.
*/
`ifndef PIN_PULSE_PARAMS_SVH
`define PIN_PULSE_PARAMS_SVH

// ************************************************************
// Register byte offsets (Avalon-MM, one aligned word each)
// ************************************************************
`define OFS_PIN1_STATE 8'h00
`define OFS_PIN1_COUNT 8'h04
`define OFS_PIN1_DUTY 8'h08
`define OFS_PIN1_PERIOD 8'h0C
`define OFS_PIN2_STATE 8'h10
`define OFS_PIN2_COUNT 8'h14
`define OFS_PIN2_DUTY 8'h18
`define OFS_PIN2_PERIOD 8'h1C
`define OFS_STATE_CHANGE_MODE_MODE 8'h20
`define OFS_STATUS 8'h24

// ************************************************************
// Field widths
// ************************************************************
`define W_MODE 2
`define W_COUNT 16
`define W_DUTY 10
`define W_PERIOD 12
`define W_PROD 22

// ************************************************************
// Encodings and limits
// ************************************************************
`define PIN_LOW 2'h0
`define PIN_HIGH 2'h1
`define PIN_PWM 2'h2
`define STATE_CHANGE_MODE_OFF 2'h0
`define STATE_CHANGE_MODE_STATE_CHANGE 2'h1
`define STATE_CHANGE_MODE_EVERY_PROGRAM 2'h2
`define COUNT_ENDLESS 16'hFFFF
`define COUNT_MIN 16'h0001
`define COUNT_MAX 16'h270F
`define DUTY_FULL 10'h3E8
`define PERIOD_MIN 12'h001
`define PERIOD_MAX 12'hE10

// ************************************************************
// Reset values
// ************************************************************
`define RST_MODE 2'h0
`define RST_COUNT 16'hFFFF
`define RST_DUTY 10'h1F4
`define RST_PERIOD 12'h3E8

// ************************************************************
// Timing: trigger-out pulse width
// ************************************************************
`define CLK_MHZ 100
`define STATE_CHANGE_MODE_PULSE_NS 1000
`define STATE_CHANGE_MODE_CYCLES ((`STATE_CHANGE_MODE_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define W_STATE_CHANGE_MODE 8

`endif

/* src/pin_pulse_pkg.sv */
/*
  Types shared by the programmable pin pulse and trigger-out block.
  Assumes the params header sits on the include path.
*/
`include "pin_pulse_params.svh"

package pin_pulse_pkg;

  // Per-pin settings and running pulse state
  typedef struct packed {
    logic [`W_MODE-1:0] mode;
    logic [`W_COUNT-1:0] count;
    logic [`W_DUTY-1:0] duty;
    logic [`W_PERIOD-1:0] period;
    logic [`W_PERIOD-1:0] ms_cnt;
    logic [`W_COUNT-1:0] left;
    logic done;
    logic level;
  } pin_t;

  // Whole block state
  typedef struct packed {
    pin_t [1:0] pin;
    logic [`W_MODE-1:0] state_change_mode_mode;
    logic [`W_STATE_CHANGE_MODE-1:0] state_change_mode_cnt;
    logic state_change_mode_level;
    logic prev_on;
    logic waitreq;
    logic [31:0] rdata;
  } state_t;

endpackage

/* tb/pin_pulse_watcher.sv */
/*
  External equipment on the rear pins: counts pin pulses and
  trigger-out high time. Assumes the bench clock drives it.
*/
module pin_pulse_watcher (
  input wire logic i_clk,
  input wire logic i_clear,
  input wire logic i_pin_one,
  input wire logic i_pin_two,
  input wire logic i_state_change_mode,
  output logic [15:0] o_one_rises,
  output logic [15:0] o_two_rises,
  output logic [15:0] o_state_change_mode_high
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // Edge counters
  // ****************
  logic [1:0] last_q; // Pin levels one cycle ago
  // Rising edges per pin; trigger width in cycles
  always_ff @(posedge i_clk) begin
    last_q <= {i_pin_two, i_pin_one};
    if (i_clear) begin
      o_one_rises <= 16'h0000;
      o_two_rises <= 16'h0000;
      o_state_change_mode_high <= 16'h0000;
    end else begin
      o_one_rises <= o_one_rises + 16'(i_pin_one & ~last_q[0]);
      o_two_rises <= o_two_rises + 16'(i_pin_two & ~last_q[1]);
      o_state_change_mode_high <= o_state_change_mode_high + 16'(i_state_change_mode);
    end
  end
endmodule

/* tb/pin_pulse_chk_assertions.sv */
/*
  Port checker for the pin pulse block.
  Assumes it is bound to the top module; one clock, sync reset.
*/
module pin_pulse_chk (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic i_ms_tick,
  input wire logic i_output_on,
  input wire logic i_param_programmed,
  input wire logic i_step_done,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_prog_pin_one,
  input wire logic o_prog_pin_two,
  input wire logic o_trigger_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // Properties
  // ****************
  logic [2:0] cause_q; // Recent tick, bus answer or reset
  // Pins may only move shortly after one of these causes
  always_ff @(posedge i_clk) begin
    cause_q <= {cause_q[1:0], i_ms_tick | ~o_waitrequest | i_reset};
  end
  default clocking @(posedge i_clk); endclocking
  a_wait_answer: assert property (disable iff (i_reset)
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("request not answered next cycle");
  a_wait_one: assert property (disable iff (i_reset)
    !o_waitrequest |=> o_waitrequest)
    else $error("answer longer than one cycle");
  a_wait_idle: assert property (disable iff (i_reset)
    !i_read && !i_write && o_waitrequest |=> o_waitrequest)
    else $error("answer without request");
  a_reset_quiet: assert property (i_reset |=> o_waitrequest &&
    o_readdata == 32'h0 && !o_prog_pin_one && !o_prog_pin_two &&
    !o_trigger_out) else $error("outputs not cleared by reset");
  a_state_change_mode_hold: assert property (disable iff (i_reset)
    $rose(o_trigger_out) |-> o_trigger_out [*8])
    else $error("trigger pulse too short");
  a_state_change_mode_cause: assert property (disable iff (i_reset)
    $rose(o_trigger_out) |-> $past(i_param_programmed) ||
    $past(i_step_done) || $past(i_output_on) != $past(i_output_on, 2))
    else $error("trigger without event");
  a_pin_one_cause: assert property (disable iff (i_reset)
    $changed(o_prog_pin_one) |-> |cause_q)
    else $error("pin one moved without cause");
  a_pin_two_cause: assert property (disable iff (i_reset)
    $changed(o_prog_pin_two) |-> |cause_q)
    else $error("pin two moved without cause");
endmodule

bind prog_pin_pulse_and_trigger_out pin_pulse_chk chk_u (.i_clk,
  .i_reset, .i_read, .i_write, .i_ms_tick, .i_output_on,
  .i_param_programmed, .i_step_done, .o_readdata, .o_waitrequest,
  .o_prog_pin_one, .o_prog_pin_two, .o_trigger_out);

/* tb/prog_pin_pulse_and_trigger_out_tb.sv */
/*
  Self-checking bench for the pin pulse block.
  Assumes a 4-cycle millisecond tick made here and the watcher model.
*/
`include "pin_pulse_params.svh"
module prog_pin_pulse_and_trigger_out_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] i_address = 8'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [3:0] i_byteenable = 4'hF; // Byte lanes, all on except one test
  logic i_ms_tick = 1'b0;
  logic i_output_on = 1'b0;
  logic i_param_programmed = 1'b0;
  logic i_seq_running = 1'b0;
  logic i_seq_state_change_mode_enable = 1'b0;
  logic i_step_done = 1'b0;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic o_prog_pin_one;
  logic o_prog_pin_two;
  logic o_trigger_out;
  logic clear = 1'b1; // Watcher counter clear
  logic [15:0] one_rises;
  logic [15:0] two_rises;
  logic [15:0] state_change_mode_high;
  logic [1:0] tick_div = 2'h0;
  int cycles = 0;
  int error_cnt = 0;
  int check_count = 0;
  prog_pin_pulse_and_trigger_out dut_u (.i_clk, .i_reset, .i_address,
    .i_read, .i_write, .i_writedata, .i_byteenable, .o_readdata,
    .o_waitrequest, .i_ms_tick, .i_output_on, .i_param_programmed,
    .i_seq_running, .i_seq_state_change_mode_enable, .i_step_done, .o_prog_pin_one,
    .o_prog_pin_two, .o_trigger_out);
  pin_pulse_watcher watch_u (.i_clk, .i_clear(clear),
    .i_pin_one(o_prog_pin_one), .i_pin_two(o_prog_pin_two),
    .i_state_change_mode(o_trigger_out), .o_one_rises(one_rises),
    .o_two_rises(two_rises), .o_state_change_mode_high(state_change_mode_high));
  always #5 i_clk = ~i_clk;
  // Short millisecond keeps pulse trains brief; hang guard
  always @(posedge i_clk) begin
    tick_div <= tick_div + 2'h1;
    i_ms_tick <= (tick_div == 2'h3);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test();
    end
  end
  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Avalon access: hold until waitrequest is sampled low
  task automatic bus(input logic rw, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    i_address <= a;
    i_writedata <= d;
    i_write <= rw;
    i_read <= ~rw;
    @(posedge i_clk);
    while (o_waitrequest !== 1'b0) @(posedge i_clk);
    q = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic pin(input int p, input logic [31:0] c, d, per, st);
    logic [7:0] b;
    b = p ? `OFS_PIN2_STATE : `OFS_PIN1_STATE;
    wr(b + 8'h04, c);
    wr(b + 8'h08, d);
    wr(b + 8'h0C, per);
    wr(b, st);
  endtask
  task automatic clr;
    clear <= 1'b1;
    @(posedge i_clk);
    clear <= 1'b0;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    for (int p = 0; p < 2; p++) begin
      rdc(8'(p * 16), 32'h0);
      rdc(8'(p * 16 + 4), 32'hFFFF);
      rdc(8'(p * 16 + 8), 32'h1F4);
      rdc(8'(p * 16 + 12), 32'h3E8);
    end
    rdc(`OFS_STATE_CHANGE_MODE_MODE, 32'h0);
    rdc(8'h28, 32'h0);
    $display("reset values done");
  endtask
  // Out-of-range writes leave the old value
  task automatic t_refuse;
    wr(`OFS_PIN2_COUNT, 32'h0);
    rdc(`OFS_PIN2_COUNT, 32'hFFFF);
    wr(`OFS_PIN2_COUNT, 32'h270F);
    wr(`OFS_PIN2_COUNT, 32'h2710);
    rdc(`OFS_PIN2_COUNT, 32'h270F);
    // Low lane only: upper byte of the count keeps its old bits
    i_byteenable <= 4'h1;
    wr(`OFS_PIN2_COUNT, 32'hFFFF_FF05);
    i_byteenable <= 4'hF;
    rdc(`OFS_PIN2_COUNT, 32'h2705);
    wr(`OFS_PIN2_DUTY, 32'h3E9);
    rdc(`OFS_PIN2_DUTY, 32'h1F4);
    wr(`OFS_PIN2_PERIOD, 32'h0);
    wr(`OFS_PIN2_PERIOD, 32'hE11);
    rdc(`OFS_PIN2_PERIOD, 32'h3E8);
    wr(`OFS_PIN2_PERIOD, 32'hE10);
    rdc(`OFS_PIN2_PERIOD, 32'hE10);
    wr(`OFS_PIN2_STATE, 32'h3);
    rdc(`OFS_PIN2_STATE, 32'h0);
    $display("range refusal done");
  endtask
  // Pulse settings change nothing in a constant state
  task automatic t_const;
    clr();
    pin(0, 32'h2, 32'h0, 32'h1, 32'(`PIN_HIGH));
    pin(0, 32'h2, 32'h0, 32'h1, 32'(`PIN_HIGH));
    repeat (60) @(posedge i_clk);
    chk(32'(o_prog_pin_one), 32'h1);
    chk(32'(one_rises), 32'h1);
    wr(`OFS_PIN1_STATE, 32'(`PIN_LOW));
    chk(32'(o_prog_pin_one), 32'h0);
    $display("constant states done");
  endtask
  task automatic t_pwm;
    clr();
    pin(0, 32'h3, 32'h1F4, 32'h4, 32'(`PIN_PWM));
    pin(1, 32'h5, 32'hFA, 32'h2, 32'(`PIN_PWM));
    repeat (300) @(posedge i_clk);
    chk(32'(one_rises), 32'h3);
    chk(32'(two_rises), 32'h5);
    chk(32'({o_prog_pin_two, o_prog_pin_one}), 32'h0);
    rdc(`OFS_STATUS, 32'h0C);
    $display("finite trains done");
  endtask
  task automatic t_endless;
    pin(0, 32'hFFFF, 32'h1F4, 32'h2, 32'(`PIN_PWM));
    pin(1, 32'hFFFF, 32'h0, 32'h2, 32'(`PIN_PWM));
    clr();
    repeat (400) @(posedge i_clk);
    chk(32'(one_rises >= 16'd49 && one_rises <= 16'd51), 32'h1);
    chk(32'(two_rises), 32'h0);
    wr(`OFS_PIN2_DUTY, 32'h3E8);
    repeat (20) @(posedge i_clk);
    clr();
    repeat (100) @(posedge i_clk);
    chk(32'({two_rises, 15'h0, o_prog_pin_two}), 32'h1);
    $display("endless trains done");
  endtask
  // Kind 0 toggles output, 1 programs a parameter, 2 ends a step
  task automatic tcase(input logic [1:0] m, input logic run, en,
                       input int kind, input logic [31:0] exp);
    wr(`OFS_STATE_CHANGE_MODE_MODE, 32'(m));
    i_seq_running <= run;
    i_seq_state_change_mode_enable <= en;
    clr();
    if (kind == 0) i_output_on <= ~i_output_on;
    i_param_programmed <= (kind == 1);
    i_step_done <= (kind == 2);
    @(posedge i_clk);
    i_param_programmed <= 1'b0;
    i_step_done <= 1'b0;
    repeat (130) @(posedge i_clk);
    chk(32'(state_change_mode_high), exp);
  endtask
  task automatic t_state_change_mode;
    for (int k = 0; k < 3; k++) tcase(`STATE_CHANGE_MODE_OFF, 1'b0, 1'b1, k, 0);
    tcase(`STATE_CHANGE_MODE_OFF, 1'b1, 1'b1, 0, 0);
    tcase(`STATE_CHANGE_MODE_STATE_CHANGE, 1'b0, 1'b0, 0, 100);
    tcase(`STATE_CHANGE_MODE_STATE_CHANGE, 1'b0, 1'b0, 1, 0);
    tcase(`STATE_CHANGE_MODE_EVERY_PROGRAM, 1'b0, 1'b0, 1, 100);
    tcase(`STATE_CHANGE_MODE_EVERY_PROGRAM, 1'b0, 1'b0, 2, 0);
    tcase(`STATE_CHANGE_MODE_STATE_CHANGE, 1'b1, 1'b0, 0, 0);
    tcase(`STATE_CHANGE_MODE_STATE_CHANGE, 1'b1, 1'b1, 0, 100);
    tcase(`STATE_CHANGE_MODE_EVERY_PROGRAM, 1'b1, 1'b0, 2, 100);
    tcase(`STATE_CHANGE_MODE_EVERY_PROGRAM, 1'b1, 1'b0, 1, 0);
    $display("trigger modes done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_refuse();
    t_const();
    t_pwm();
    t_endless();
    t_state_change_mode();
    end_of_test();
  end
endmodule
